// [hw/wdts_pkg.sv]
package wdts_pkg;
	// register offsets on the plain register port
	localparam logic [3:0] WDTS_OFS_CONTROL = 4'h0;
	localparam logic [3:0] WDTS_OFS_RST_FLAG = 4'h1;
	localparam logic [3:0] WDTS_OFS_IRQ_STATUS = 4'h2;
	localparam logic [3:0] WDTS_OFS_IRQ_MASK = 4'h3;

	// watchdog_control field positions
	localparam int WDTS_BIT_UNLOCK = 4;
	localparam int WDTS_BIT_ENABLE = 3;
	localparam int WDTS_PS_HI = 2;
	localparam int WDTS_PS_LO = 0;

	// irq status bit positions
	localparam int WDTS_IRQ_TIMEOUT = 0;
	localparam int WDTS_IRQ_BLOCKED = 1;

	// reset values
	localparam logic [2:0] WDTS_PS_RESET = 3'h0;
	localparam logic [1:0] WDTS_IRQ_RESET = 2'h0;

	// unlock window length in system clock cycles
	localparam logic [2:0] WDTS_UNLOCK_CYCLES = 3'h4;

	// timing: system clock and watchdog oscillator, in ns
	localparam int WDTS_SYS_PERIOD_NS = 100;
	localparam int WDTS_OSC_PERIOD_NS = 1000;
	localparam int WDTS_OSC_RATIO = WDTS_OSC_PERIOD_NS / WDTS_SYS_PERIOD_NS;

	// shortest time-out in oscillator cycles
	localparam int WDTS_BASE_CYCLES = 16384;
	localparam int WDTS_PS_STEPS = 8;

	typedef enum logic [1:0] {
		WDTS_LEVEL0 = 2'h0,
		WDTS_LEVEL1 = 2'h1,
		WDTS_LEVEL2 = 2'h3
	} wdts_level_t;
endpackage

// [hw/wdts_tick_div.sv]
`timescale 1ns/100ps
module wdts_tick_div #(
	parameter int RATIO = 10
) (
	input  wire logic sys_clk,
	input  wire logic sys_rst,
	output logic      tick
);
	localparam int CW = (RATIO < 2) ? 1 : $clog2(RATIO);

	generate
		if (RATIO < 2) begin : g_bad
			$error("wdts_tick_div: RATIO must be at least 2");
		end
	endgenerate

	logic [CW-1:0] cnt;
	wire           wrap = (cnt == CW'(RATIO - 1));

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			cnt <= '0;
			tick <= 1'b0;
		end else begin
			cnt <= wrap ? '0 : cnt + CW'(1);
			tick <= wrap;
		end
	end
endmodule

// [hw/wdts_top.sv]
// Design decisions made here: the strobed register port and the register offsets.
`timescale 1ns/100ps
module wdts_top
	import wdts_pkg::*;
#(
	parameter int BASE_CYCLES = WDTS_BASE_CYCLES,
	parameter int OSC_RATIO   = WDTS_OSC_RATIO,
	parameter int CNT_W       = 22
) (
	input  wire logic       sys_clk,
	input  wire logic       sys_rst,
	input  wire logic       chip_reset_in,
	input  wire logic       legacy_compat_fuse,
	input  wire logic       always_on_fuse,
	input  wire logic       restart_instruction,
	input  wire logic [3:0] reg_addr,
	input  wire logic [7:0] reg_wdata,
	input  wire logic       reg_wr,
	input  wire logic       reg_rd,
	output logic      [7:0] reg_rdata,
	output logic            chip_reset_pulse,
	output logic            irq
);
	generate
		if (BASE_CYCLES < 2 || CNT_W > 31 ||
		    (longint'(BASE_CYCLES) << (WDTS_PS_STEPS - 1)) > (longint'(1) << CNT_W)) begin : g_bad
			$error("wdts_top: BASE_CYCLES does not fit CNT_W");
		end
	endgenerate

	// safety level, taken from the fuses while reset is held
	logic        fuse_compat;
	logic        fuse_on;
	wdts_level_t level;

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			fuse_compat <= legacy_compat_fuse;
			fuse_on <= always_on_fuse;
		end
	end

	assign level = fuse_on ? WDTS_LEVEL2 :
	               (fuse_compat ? WDTS_LEVEL0 : WDTS_LEVEL1);
	wire lvl2 = (level == WDTS_LEVEL2);

	// oscillator tick enable
	logic osc_tick;

	wdts_tick_div #(
		.RATIO (OSC_RATIO)
	) u_osc (
		.sys_clk (sys_clk),
		.sys_rst (sys_rst),
		.tick    (osc_tick)
	);

	// control state
	logic       unlock_bit;
	logic       enable_bit;
	logic [2:0] prescale_select;
	logic [2:0] unlock_cnt;
	logic       guard_reset_flag;
	logic [1:0] irq_status;
	logic [1:0] irq_mask;
	logic       timeout;
	logic       rst_started;

	// chip reset covers power-on, external and our own time-out
	wire chip_rst = sys_rst | chip_reset_in | chip_reset_pulse;

	// register decode
	wire wr_ctl  = reg_wr & (reg_addr == WDTS_OFS_CONTROL);
	wire wr_flag = reg_wr & (reg_addr == WDTS_OFS_RST_FLAG);
	wire wr_ist  = reg_wr & (reg_addr == WDTS_OFS_IRQ_STATUS);
	wire wr_imsk = reg_wr & (reg_addr == WDTS_OFS_IRQ_MASK);

	wire       w_unlock = reg_wdata[WDTS_BIT_UNLOCK];
	wire       w_enable = reg_wdata[WDTS_BIT_ENABLE];
	wire [2:0] w_ps     = reg_wdata[WDTS_PS_HI:WDTS_PS_LO];

	// write effects on the control register
	wire open_seq   = wr_ctl & w_unlock & w_enable;
	wire in_window  = unlock_bit;
	wire confirm    = wr_ctl & in_window & ~w_unlock;
	wire dis_ok     = (level == WDTS_LEVEL0) ? in_window : confirm;
	wire do_disable = wr_ctl & ~w_enable & dis_ok & ~lvl2;
	wire blocked    = wr_ctl & ~w_enable & enable_bit & ~do_disable;
	wire ps_ok      = (level == WDTS_LEVEL0) ? wr_ctl : confirm;

	logic       next_enable;
	logic       next_unlock;
	logic [2:0] next_unlock_cnt;
	logic [2:0] next_ps;

	always_comb begin
		next_enable = enable_bit;
		if (lvl2) begin
			next_enable = 1'b1;
		end else if (wr_ctl && w_enable) begin
			next_enable = 1'b1;
		end else if (do_disable) begin
			next_enable = 1'b0;
		end
		next_unlock = unlock_bit;
		next_unlock_cnt = unlock_cnt;
		if (open_seq) begin
			next_unlock = 1'b1;
			next_unlock_cnt = WDTS_UNLOCK_CYCLES;
		end else if (wr_ctl && w_unlock) begin
			next_unlock = 1'b1;
			next_unlock_cnt = WDTS_UNLOCK_CYCLES;
		end else if (confirm) begin
			next_unlock = 1'b0;
			next_unlock_cnt = '0;
		end else if (unlock_cnt != 3'h0) begin
			next_unlock_cnt = unlock_cnt - 3'h1;
			next_unlock = (unlock_cnt != 3'h1);
		end
		next_ps = ps_ok ? w_ps : prescale_select;
	end

	always_ff @(posedge sys_clk) begin
		if (chip_rst) begin
			unlock_bit <= 1'b0;
			unlock_cnt <= '0;
			enable_bit <= 1'b0;
			prescale_select <= WDTS_PS_RESET;
		end else begin
			unlock_bit <= next_unlock;
			unlock_cnt <= next_unlock_cnt;
			enable_bit <= next_enable;
			prescale_select <= next_ps;
		end
	end

	// effective enable: level 2 runs from reset onward
	wire run = enable_bit | lvl2;

	// restart request held until the next oscillator tick
	logic restart_pend;

	always_ff @(posedge sys_clk) begin
		if (chip_rst) begin
			restart_pend <= 1'b0;
		end else if (restart_instruction) begin
			restart_pend <= 1'b1;
		end else if (osc_tick) begin
			restart_pend <= 1'b0;
		end
	end

	// settings as seen by the oscillator side, updated only on ticks
	logic [2:0] osc_ps;
	logic       osc_run;

	always_ff @(posedge sys_clk) begin
		if (chip_rst) begin
			osc_ps <= WDTS_PS_RESET;
			osc_run <= 1'b0;
		end else if (osc_tick) begin
			osc_ps <= prescale_select;
			osc_run <= run;
		end
	end

	// time-out length in oscillator cycles
	wire [CNT_W-1:0] base_len = CNT_W'(BASE_CYCLES);
	wire [CNT_W-1:0] period   = base_len << osc_ps;
	wire [CNT_W-1:0] last_cnt = period - CNT_W'(1);

	logic [CNT_W-1:0] wd_cnt;
	wire              clr_cnt = restart_pend | ~osc_run | ~run;
	wire              expire  = osc_tick & osc_run & run & ~restart_pend &
	                            (wd_cnt >= last_cnt);

	always_ff @(posedge sys_clk) begin
		if (chip_rst) begin
			wd_cnt <= '0;
		end else if (osc_tick) begin
			if (clr_cnt || expire) begin
				wd_cnt <= '0;
			end else begin
				wd_cnt <= wd_cnt + CNT_W'(1);
			end
		end
	end

	assign timeout = expire & ~rst_started;

	// one-cycle reset pulse on time-out
	always_ff @(posedge sys_clk) begin
		if (sys_rst || chip_reset_in) begin
			chip_reset_pulse <= 1'b0;
			rst_started <= 1'b0;
		end else begin
			chip_reset_pulse <= timeout;
			rst_started <= timeout;
		end
	end

	// watchdog reset flag survives every reset but power-on
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			guard_reset_flag <= 1'b0;
		end else if (timeout) begin
			guard_reset_flag <= 1'b1;
		end else if (wr_flag && !reg_wdata[0]) begin
			guard_reset_flag <= 1'b0;
		end
	end

	// interrupt status, write one to clear, set wins
	wire [1:0] irq_set = {blocked, timeout};
	wire [1:0] irq_clr = wr_ist ? reg_wdata[1:0] : 2'h0;

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			irq_status <= WDTS_IRQ_RESET;
			irq_mask <= WDTS_IRQ_RESET;
		end else begin
			irq_status <= (irq_status & ~irq_clr) | irq_set;
			if (wr_imsk) begin
				irq_mask <= reg_wdata[1:0];
			end
		end
	end

	assign irq = |(irq_status & irq_mask);

	// read data, valid only in the cycle after the read strobe
	wire       rd_enable = enable_bit | lvl2;
	wire [7:0] ctl_view  = {3'h0, unlock_bit, rd_enable, prescale_select};

	logic [7:0] rd_mux;

	always_comb begin
		case (reg_addr)
			WDTS_OFS_CONTROL:    rd_mux = ctl_view;
			WDTS_OFS_RST_FLAG:   rd_mux = {7'h0, guard_reset_flag};
			WDTS_OFS_IRQ_STATUS: rd_mux = {6'h0, irq_status};
			WDTS_OFS_IRQ_MASK:   rd_mux = {6'h0, irq_mask};
			default:             rd_mux = 8'h00;
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			reg_rdata <= 8'h00;
		end else begin
			reg_rdata <= reg_rd ? rd_mux : 8'h00;
		end
	end
endmodule

// [sim/tb_wdts_top.sv]
`timescale 1ns/100ps
module tb_wdts_top;
	import wdts_pkg::*;
	localparam int BASE  = 8;
	localparam int RATIO = 10;
	logic       clk = 1'b0;
	logic       rst = 1'b1;
	logic       cri = 1'b0;
	logic       lcf = 1'b0;
	logic       aof = 1'b0;
	logic       rsi = 1'b0;
	logic       wrs = 1'b0;
	logic       rds = 1'b0;
	logic [3:0] adr = 4'h0;
	logic [7:0] wd  = 8'h00;
	wire  [7:0] rdat;
	wire        pls;
	wire        irq;
	int         mismatches = 0, checks = 0, cyc = 0, ulk = -100, lvl, en, ps, flag, sts, msk, n;
	wdts_top #(.BASE_CYCLES(BASE), .OSC_RATIO(RATIO), .CNT_W(22)) u_wdts_top (
		.sys_clk(clk), .sys_rst(rst), .chip_reset_in(cri), .legacy_compat_fuse(lcf),
		.always_on_fuse(aof), .restart_instruction(rsi), .reg_addr(adr), .reg_wdata(wd),
		.reg_wr(wrs), .reg_rd(rds), .reg_rdata(rdat), .chip_reset_pulse(pls), .irq(irq));
	initial begin
		forever #50 clk = ~clk;
	end
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			mismatches++;
			report_and_stop();
		end
	end
	task automatic chk(string nm, logic [7:0] e, logic [7:0] g);
		checks++;
		if (g !== e) begin
			mismatches++;
			$display("unexpected %s expected %h seen %h", nm, e, g);
		end
	endtask
	function automatic bit opened();
		return cyc - ulk >= 1 && cyc - ulk <= 4;
	endfunction
	task automatic wr(logic [3:0] a, logic [7:0] d);
		bit o;
		o = opened();
		wrs <= 1'b1;
		adr <= a;
		wd <= d;
		if (a == WDTS_OFS_CONTROL) begin
			if (!d[3] && en != 0 && (lvl == 2 || !o || (lvl == 1 && d[4]))) sts = sts | 2;
			if (d[4]) ulk = cyc;
			if (lvl == 0) ps = d[2:0];
			if (lvl == 0 && o && !d[3]) en = 0;
			if (lvl != 0 && o && !d[4]) begin
				ps = d[2:0];
				en = lvl == 2 || d[3];
				ulk = -100;
			end
			en = en | d[3] | (lvl == 2);
		end
		if (a == WDTS_OFS_RST_FLAG && !d[0]) flag = 0;
		if (a == WDTS_OFS_IRQ_STATUS) sts = sts & ~d;
		if (a == WDTS_OFS_IRQ_MASK) msk = d;
		@(posedge clk);
		wrs <= 1'b0;
		@(posedge clk);
	endtask
	task automatic rd(string nm, logic [3:0] a);
		logic [7:0] e;
		case (a)
			WDTS_OFS_CONTROL: e = {3'h0, opened(), en[0], ps[2:0]};
			WDTS_OFS_RST_FLAG: e = 8'(flag);
			WDTS_OFS_IRQ_STATUS: e = 8'(sts);
			WDTS_OFS_IRQ_MASK: e = 8'(msk);
			default: e = 8'h00;
		endcase
		rds <= 1'b1;
		adr <= a;
		@(posedge clk);
		rds <= 1'b0;
		#1 chk(nm, e, rdat);
		@(posedge clk);
	endtask
	task automatic reset_to(logic l, logic a);
		rst <= 1'b1;
		lcf <= l;
		aof <= a;
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		lvl = a ? 2 : (l ? 0 : 1);
		en = lvl == 2;
		ps = 0;
		flag = 0;
		sts = 0;
		msk = 0;
		ulk = -100;
	endtask
	task automatic expire(int p);
		rsi <= 1'b1;
		@(posedge clk);
		rsi <= 1'b0;
		n = 0;
		while (pls !== 1'b1 && n < 30000) begin
			@(posedge clk);
			#1 n++;
		end
		chk("timeout", 8'h01, 8'(n >= ((BASE << p) - 1) * RATIO && n <= ((BASE << p) + 2) * RATIO));
		en = lvl == 2;
		ps = 0;
		ulk = -100;
		flag = 1;
		sts = sts | 1;
		@(posedge clk);
	endtask
	initial begin
		void'($urandom(96996));
		reset_to(1'b0, 1'b0);
		rd("control", WDTS_OFS_CONTROL);
		wr(4'h9, 8'($urandom));
		rd("unmapped", 4'h9);
		wr(WDTS_OFS_CONTROL, 8'h08);
		wr(WDTS_OFS_CONTROL, 8'h00);
		rd("locked", WDTS_OFS_CONTROL);
		wr(WDTS_OFS_CONTROL, 8'h18);
		rd("unlock", WDTS_OFS_CONTROL);
		rd("unlock", WDTS_OFS_CONTROL);
		wr(WDTS_OFS_CONTROL, 8'h0d);
		rd("late change", WDTS_OFS_CONTROL);
		wr(WDTS_OFS_CONTROL, 8'h18);
		@(posedge clk);
		rd("unlock", WDTS_OFS_CONTROL);
		rd("unlock closed", WDTS_OFS_CONTROL);
		wr(WDTS_OFS_CONTROL, 8'h18);
		wr(WDTS_OFS_CONTROL, 8'h0d);
		rd("timed change", WDTS_OFS_CONTROL);
		wr(WDTS_OFS_CONTROL, 8'h18);
		wr(WDTS_OFS_CONTROL, 8'h00);
		rd("timed disable", WDTS_OFS_CONTROL);
		wr(WDTS_OFS_CONTROL, 8'h08);
		cri <= 1'b1;
		@(posedge clk);
		cri <= 1'b0;
		en = 0;
		ps = 0;
		rd("chip reset", WDTS_OFS_CONTROL);
		rd("blocked", WDTS_OFS_IRQ_STATUS);
		$display("level one done");
		reset_to(1'b1, 1'b0);
		wr(WDTS_OFS_IRQ_MASK, 8'h01);
		for (int p = 0; p < 8; p++) begin
			wr(WDTS_OFS_CONTROL, {3'($urandom), 2'b01, 3'(p)});
			rd("prescale", WDTS_OFS_CONTROL);
			expire(p);
		end
		rd("flag", WDTS_OFS_RST_FLAG);
		wr(WDTS_OFS_RST_FLAG, 8'h00);
		rd("flag", WDTS_OFS_RST_FLAG);
		chk("irq", 8'h01, 8'(irq));
		wr(WDTS_OFS_IRQ_MASK, 8'h00);
		chk("irq", 8'h00, 8'(irq));
		wr(WDTS_OFS_IRQ_MASK, 8'h01);
		wr(WDTS_OFS_IRQ_STATUS, 8'h01);
		chk("irq", 8'h00, 8'(irq));
		rd("status", WDTS_OFS_IRQ_STATUS);
		$display("level zero done");
		reset_to(1'b0, 1'b1);
		rd("always on", WDTS_OFS_CONTROL);
		wr(WDTS_OFS_CONTROL, 8'h18);
		wr(WDTS_OFS_CONTROL, 8'h02);
		rd("level two change", WDTS_OFS_CONTROL);
		wr(WDTS_OFS_CONTROL, 8'h18);
		wr(WDTS_OFS_CONTROL, 8'h00);
		rd("level two locked", WDTS_OFS_CONTROL);
		rd("blocked", WDTS_OFS_IRQ_STATUS);
		$display("level two done");
		report_and_stop();
	end
endmodule

// [sim/wdts_chk.sv]
`timescale 1ns/100ps
module wdts_chk
	import wdts_pkg::*;
#(
	parameter int BASE_CYCLES = 16384,
	parameter int OSC_RATIO   = 10
) (
	input wire logic       sys_clk,
	input wire logic       sys_rst,
	input wire logic       chip_reset_in,
	input wire logic       legacy_compat_fuse,
	input wire logic       always_on_fuse,
	input wire logic       restart_instruction,
	input wire logic [3:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic       reg_wr,
	input wire logic       reg_rd,
	input wire logic [7:0] reg_rdata,
	input wire logic       chip_reset_pulse,
	input wire logic       irq
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (sys_rst);
	logic lvl2;
	logic flag_m;
	logic mask_m;
	int   since;
	wire  ctl_rd = reg_rd && reg_addr == WDTS_OFS_CONTROL;
	wire  ulk_wr = reg_wr && reg_addr == WDTS_OFS_CONTROL && reg_wdata[WDTS_BIT_UNLOCK];
	wire  quiet  = !reg_wr && !chip_reset_in && !chip_reset_pulse;
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			lvl2   <= always_on_fuse;
			flag_m <= 1'b0;
			mask_m <= 1'b0;
		end else begin
			if (chip_reset_pulse) flag_m <= 1'b1;
			else if (reg_wr && reg_addr == WDTS_OFS_RST_FLAG && !reg_wdata[0]) flag_m <= 1'b0;
			if (reg_wr && reg_addr == WDTS_OFS_IRQ_MASK) mask_m <= reg_wdata[0];
		end
	end
	// cycles since the counter was last cleared
	always_ff @(posedge sys_clk) begin
		if (sys_rst || restart_instruction || chip_reset_in || chip_reset_pulse) since <= 0;
		else if (since < BASE_CYCLES * OSC_RATIO) since <= since + 1;
	end
	pulse_single_a: assert property (chip_reset_pulse |=> !chip_reset_pulse)
		else $error("reset pulse too long");
	timeout_gap_a: assert property (chip_reset_pulse |-> since >= (BASE_CYCLES - 1) * OSC_RATIO)
		else $error("time-out too early");
	rsvd_zero_a: assert property (ctl_rd |=> reg_rdata[7:5] == 3'h0)
		else $error("reserved control bits set");
	lvl2_enable_a: assert property (ctl_rd && lvl2 |=> reg_rdata[WDTS_BIT_ENABLE])
		else $error("enable low in level two");
	unlock_hold_a: assert property (ulk_wr ##1 quiet [*3] ##1 (quiet && ctl_rd) |=> reg_rdata[4])
		else $error("unlock closed early");
	unlock_close_a: assert property (ulk_wr ##1 quiet [*4] ##1 ctl_rd |=> !reg_rdata[4])
		else $error("unlock still open");
	flag_track_a: assert property (reg_rd && reg_addr == WDTS_OFS_RST_FLAG |=> reg_rdata[0] == flag_m)
		else $error("reset flag wrong");
	irq_raise_a: assert property (chip_reset_pulse && mask_m |-> irq)
		else $error("irq missing on time-out");
endmodule
bind wdts_top wdts_chk #(.BASE_CYCLES(BASE_CYCLES), .OSC_RATIO(OSC_RATIO)) u_wdts_chk (
	.sys_clk(sys_clk), .sys_rst(sys_rst), .chip_reset_in(chip_reset_in),
	.legacy_compat_fuse(legacy_compat_fuse), .always_on_fuse(always_on_fuse),
	.restart_instruction(restart_instruction), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
	.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
	.chip_reset_pulse(chip_reset_pulse), .irq(irq));
